// ===== verilog/qdds_pkg.sv
// Shared constants for the four-channel phase core
package qdds_pkg;
  localparam int QDDS_NUM_CH = 4;
  localparam int QDDS_ACC_W = 32;
  localparam int QDDS_OFS_W = 14;
  localparam int QDDS_AMP_W = 10;
  localparam int QDDS_LUT_AW = 8;
  localparam int QDDS_FIFO_DEPTH = 4;
  localparam logic [31:0] QDDS_FTW_RST = 32'h0000_0000;
  localparam logic [13:0] QDDS_OFS_RST = 14'h0000;
  localparam logic [1:0] QDDS_SYNC_DIV_LAST = 2'h3;
  localparam logic [1:0] QDDS_SYNC_HIGH_FROM = 2'h2;
  localparam int QDDS_CMD_W = 2 + 1 + QDDS_ACC_W;
  localparam logic QDDS_SEL_FREQ = 1'b0;
  localparam logic QDDS_SEL_OFS = 1'b1;
  localparam int QDDS_SYNC_CLK_DIV = 4;
endpackage

// ===== verilog/qdds_fifo.sv
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module qdds_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic do_wr, do_rd;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (do_wr) begin
      mem_next[wr_reg] = in_data;
      wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (do_rd) begin
      rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    if (do_wr && !do_rd) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (do_rd && !do_wr) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    mem_reg <= mem_next;
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ===== verilog/qdds_cos_rom.sv
// Registered cosine table, amplitude in offset binary
`timescale 1ns/1ps
module qdds_cos_rom #(
  parameter int AW = 8,
  parameter int DW = 10
) (
  // Clock
  input wire logic clk,
  // Lookup
  input wire logic [AW-1:0] phase,
  output logic [DW-1:0] amp
);
  localparam int N = 1 << AW;
  localparam real PI = 3.14159265358979;
  logic [DW-1:0] table_c [N];
  logic [DW-1:0] amp_reg;

  // Table computed at elaboration; no file to load
  generate
    for (genvar i = 0; i < N; i++) begin : g_tab
      localparam real MID = (2.0 ** (DW - 1)) - 0.5;
      localparam int V = int'(MID + MID * $cos(2.0 * PI * i / N));
      assign table_c[i] = DW'(V);
    end
  endgenerate

  always_ff @(posedge clk) begin
    amp_reg <= table_c[phase];
  end
  assign amp = amp_reg;
endmodule

// ===== verilog/qdds_core.sv
// Four-channel phase accumulator core with buffered tuning words
`timescale 1ns/1ps
module qdds_core
  import qdds_pkg::*;
#(
  parameter int NUM_CH = qdds_pkg::QDDS_NUM_CH,
  parameter int FIFO_DEPTH = qdds_pkg::QDDS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Word write port
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [1:0] wr_chan,
  input wire logic wr_sel,
  input wire logic [qdds_pkg::QDDS_ACC_W-1:0] wr_data,
  // Load strobe pin and sync clock
  input wire logic io_load,
  output logic sync_clk,
  // Converter codes
  output logic [NUM_CH*qdds_pkg::QDDS_AMP_W-1:0] dac_code
);
  import qdds_pkg::*;

  typedef enum logic [1:0] {
    QDDS_LD_IDLE = 2'b01,
    QDDS_LD_ARMED = 2'b10
  } qdds_ld_state_t;

  // ==========================================================
  // Command FIFO feeding the buffer registers
  // ==========================================================
  logic f_valid;
  logic [QDDS_CMD_W-1:0] f_data;
  logic [1:0] f_chan;
  logic f_sel;
  logic [QDDS_ACC_W-1:0] f_word;

  qdds_fifo #(
    .WIDTH(QDDS_CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_chan, wr_sel, wr_data}),
    .out_valid(f_valid),
    .out_ready(1'b1),
    .out_data(f_data)
  );
  // Drain waits on nothing; back-pressure only if writes outrun clk
  assign f_chan = f_data[QDDS_CMD_W-1 -: 2];
  assign f_sel = f_data[QDDS_ACC_W];
  assign f_word = f_data[QDDS_ACC_W-1:0];

  // ==========================================================
  // Quarter-rate sync clock and load strobe sampling
  // ==========================================================
  logic [1:0] div_reg, div_next;
  logic sync_reg, sync_next;
  logic ld_m_reg, ld_s_reg, ld_prev_reg;
  logic ld_m_next, ld_s_next, ld_prev_next;
  qdds_ld_state_t ld_st_reg, ld_st_next;
  logic apply;

  always_comb begin
    div_next = (div_reg == QDDS_SYNC_DIV_LAST) ? 2'h0 : div_reg + 2'h1;
    sync_next = (div_next >= QDDS_SYNC_HIGH_FROM);
    ld_m_next = io_load;
    ld_s_next = ld_m_reg;
    ld_prev_next = ld_prev_reg;
    ld_st_next = ld_st_reg;
    apply = 1'b0;
    // Strobe only looked at once per sync period, at its falling edge
    if (div_reg == QDDS_SYNC_DIV_LAST) begin
      ld_prev_next = ld_s_reg;
      case (ld_st_reg)
        QDDS_LD_IDLE: begin
          if (ld_s_reg && !ld_prev_reg) begin
            apply = 1'b1;
            ld_st_next = QDDS_LD_ARMED;
          end
        end
        QDDS_LD_ARMED: begin
          if (!ld_s_reg) begin
            ld_st_next = QDDS_LD_IDLE;
          end
        end
        default: ld_st_next = QDDS_LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    ld_m_reg <= ld_m_next;
    ld_s_reg <= ld_s_next;
    if (rst) begin
      div_reg <= 2'h0;
      sync_reg <= 1'b0;
      ld_prev_reg <= 1'b0;
      ld_st_reg <= QDDS_LD_IDLE;
    end else begin
      div_reg <= div_next;
      sync_reg <= sync_next;
      ld_prev_reg <= ld_prev_next;
      ld_st_reg <= ld_st_next;
    end
  end
  assign sync_clk = sync_reg;

  // ==========================================================
  // Per-channel buffer, active words and datapath
  // ==========================================================
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [QDDS_ACC_W-1:0] ftw_buf_reg, ftw_buf_next;
      logic [QDDS_OFS_W-1:0] ofs_buf_reg, ofs_buf_next;
      logic [QDDS_ACC_W-1:0] freq_tuning_word_reg, freq_tuning_word_next;
      logic [QDDS_OFS_W-1:0] chan_phase_offset_word_reg;
      logic [QDDS_OFS_W-1:0] chan_phase_offset_word_next;
      logic [QDDS_ACC_W-1:0] acc_reg, acc_next;
      logic [QDDS_LUT_AW-1:0] lut_addr_reg, lut_addr_next;
      logic [QDDS_OFS_W-1:0] phase_offset_value;
      logic hit;

      always_comb begin
        hit = f_valid && (f_chan == 2'(c));
        ftw_buf_next = ftw_buf_reg;
        ofs_buf_next = ofs_buf_reg;
        if (hit && f_sel == QDDS_SEL_FREQ) begin
          ftw_buf_next = f_word;
        end else if (hit && f_sel == QDDS_SEL_OFS) begin
          ofs_buf_next = f_word[QDDS_OFS_W-1:0];
        end
        freq_tuning_word_next = freq_tuning_word_reg;
        chan_phase_offset_word_next = chan_phase_offset_word_reg;
        if (apply) begin
          freq_tuning_word_next = ftw_buf_reg;
          chan_phase_offset_word_next = ofs_buf_reg;
        end
        // Natural 32-bit overflow gives the wrap
        acc_next = acc_reg + freq_tuning_word_reg;
        // Offset sits on the top 14 bits: one lsb is 1/2^14 cycle
        phase_offset_value = acc_reg[QDDS_ACC_W-1 -: QDDS_OFS_W]
          + chan_phase_offset_word_reg;
        lut_addr_next = phase_offset_value[QDDS_OFS_W-1 -: QDDS_LUT_AW];
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          ftw_buf_reg <= QDDS_FTW_RST;
          ofs_buf_reg <= QDDS_OFS_RST;
          freq_tuning_word_reg <= QDDS_FTW_RST;
          chan_phase_offset_word_reg <= QDDS_OFS_RST;
          acc_reg <= QDDS_FTW_RST;
          lut_addr_reg <= '0;
        end else begin
          ftw_buf_reg <= ftw_buf_next;
          ofs_buf_reg <= ofs_buf_next;
          freq_tuning_word_reg <= freq_tuning_word_next;
          chan_phase_offset_word_reg <= chan_phase_offset_word_next;
          acc_reg <= acc_next;
          lut_addr_reg <= lut_addr_next;
        end
      end

      qdds_cos_rom #(
        .AW(QDDS_LUT_AW),
        .DW(QDDS_AMP_W)
      ) u_rom (
        .clk(clk),
        .phase(lut_addr_reg),
        .amp(dac_code[c*QDDS_AMP_W +: QDDS_AMP_W])
      );
    end
  endgenerate
endmodule

// ===== dv/qdds_core_assertions.sv
// Concurrent checks on the phase core ports
`timescale 1ns/1ps
module qdds_core_checker #(
  parameter int NUM_CH = 4,
  parameter int FIFO_DEPTH = 4
) (
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [1:0] wr_chan,
  input wire logic wr_sel,
  input wire logic [31:0] wr_data,
  input wire logic io_load,
  input wire logic sync_clk,
  input wire logic [NUM_CH*10-1:0] dac_code
);
  // ==========
  // Helper state
  logic loaded_reg;
  logic [3:0] idle_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_reg <= 1'b0;
      idle_reg <= 4'h0;
    end else begin
      loaded_reg <= loaded_reg | io_load;
      idle_reg <= (idle_reg == 4'hF) ? idle_reg : idle_reg + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // Properties
  a_sync_high_two: assert property ($rose(sync_clk) |=>
    sync_clk ##1 !sync_clk)
    else $error("sync clock high phase wrong");
  a_sync_low_two: assert property ($fell(sync_clk) |=>
    !sync_clk ##1 sync_clk)
    else $error("sync clock low phase wrong");
  a_sync_period: assert property ($rose(sync_clk) |->
    ##4 $rose(sync_clk))
    else $error("sync clock period wrong");
  a_sync_after_rst: assert property ($fell(rst) |->
    !sync_clk ##1 !sync_clk)
    else $error("sync clock not low after reset");
  a_ready_after_rst: assert property ($fell(rst) |-> wr_ready)
    else $error("write port not ready after reset");
  a_write_kept: assert property (wr_valid && wr_ready |=> wr_ready)
    else $error("write port stalled");
  a_idle_cosine: assert property (!loaded_reg && idle_reg > 4'h5 |->
    dac_code == {NUM_CH{10'h3FF}}) else $error("code moved without load");
  a_code_settle: assert property ($fell(rst) |->
    ##5 dac_code == {NUM_CH{10'h3FF}}) else $error("code not at peak");
  c_load: cover property ($rose(io_load));
  c_write: cover property (wr_valid && wr_ready);
  c_trough: cover property (loaded_reg && dac_code[9:0] == 10'h000);
endmodule

// ===== dv/qdds_dac_model.sv
// Four converter inputs latching their codes each clock
`timescale 1ns/1ps
module qdds_dac_model (
  // Clock and codes
  input wire logic clk,
  input wire logic [39:0] code,
  // Latched samples
  output logic [9:0] sample [4]
);
  always_ff @(posedge clk) begin
    for (int c = 0; c < 4; c++) begin
      sample[c] <= code[c*10+:10];
    end
  end
endmodule

// ===== dv/qdds_core_bench.sv
// Self-checking bench for the four-channel phase core
`timescale 1ns/1ps
module qdds_core_bench;
  import qdds_pkg::*;
  logic clk, rst, wr_valid, wr_sel, io_load, wr_ready, sync_clk;
  logic [1:0] wr_chan;
  logic [31:0] wr_data;
  logic [39:0] dac_code;
  logic [9:0] smp [4];
  logic [9:0] prev;
  int mismatches, compares, cyc, hi;
  qdds_core i_qdds_core (.clk(clk), .rst(rst), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_chan(wr_chan), .wr_sel(wr_sel),
    .wr_data(wr_data), .io_load(io_load), .sync_clk(sync_clk),
    .dac_code(dac_code));
  qdds_dac_model i_qdds_dac_model (.clk(clk), .code(dac_code), .sample(smp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Holds the request until taken; caller releases
  task automatic put(logic [1:0] ch, logic sel, logic [31:0] d);
    wr_valid <= 1'b1;
    wr_chan <= ch;
    wr_sel <= sel;
    wr_data <= d;
    do @(negedge clk); while (wr_ready !== 1'b1);
    @(posedge clk);
  endtask
  task automatic t_reset();
    hi = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    for (int c = 0; c < 4; c++) check("reset code", smp[c], 10'h3FF);
    repeat (16) @(negedge clk) hi += sync_clk;
    check("sync high count", 10'(hi), 10'h008);
    // Next scenario must start on a rising edge
    @(posedge clk);
  endtask
  task automatic t_no_load();
    put(2'h0, QDDS_SEL_FREQ, 32'h8000_0000);
    wr_valid <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("unloaded ch0", smp[0], 10'h3FF);
    @(posedge clk);
  endtask
  // ==========
  // Back-to-back words, then one load for all channels
  task automatic t_load();
    put(2'h1, QDDS_SEL_OFS, 32'h0000_2000);
    put(2'h2, QDDS_SEL_FREQ, 32'h8000_0000);
    put(2'h2, QDDS_SEL_OFS, 32'h0000_2000);
    put(2'h3, QDDS_SEL_FREQ, 32'h8000_0000);
    put(2'h3, QDDS_SEL_FREQ, 32'h0000_0000);
    wr_valid <= 1'b0;
    io_load <= 1'b1;
    repeat (8) @(posedge clk);
    io_load <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk) prev = smp[0];
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      check("ch0 flip", smp[0] ^ prev, 10'h3FF);
      check("ch2 vs ch0", smp[0] ^ smp[2], 10'h3FF);
      check("ch1 offset", smp[1], 10'h000);
      check("ch3 last word", smp[3], 10'h3FF);
      prev = smp[0];
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    wr_valid = 1'b0;
    wr_chan = 2'h0;
    wr_sel = 1'b0;
    wr_data = 32'h0;
    io_load = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_no_load();
    t_load();
    report_and_stop();
  end
endmodule
bind qdds_core qdds_core_checker #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH))
  i_qdds_core_checker (.clk(clk), .rst(rst), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_chan(wr_chan), .wr_sel(wr_sel),
  .wr_data(wr_data), .io_load(io_load), .sync_clk(sync_clk),
  .dac_code(dac_code));
